//--- hdl/rshr_params.svh
`ifndef RSHR_PARAMS_SVH
`define RSHR_PARAMS_SVH
`define RSHR_ADDR_CTRL      8'h00
`define RSHR_ADDR_CFG       8'h04
`define RSHR_ADDR_SUBST     8'h08
`define RSHR_ADDR_STATUS    8'h0c
`define RSHR_ADDR_IRQ_STAT  8'h10
`define RSHR_ADDR_IRQ_MASK  8'h14
`define RSHR_CTRL_ACK_REQ   0
`define RSHR_CFG_REACT_LSB  0
`define RSHR_CFG_RUN_BIT    4
`define RSHR_CFG_LOAD_BIT   8
`define RSHR_ST_FLAG        0
`define RSHR_ST_DONE        1
`define RSHR_ST_COUNT       2
`define RSHR_ST_MEAS        3
`define RSHR_ST_CPU_STOP    4
`define RSHR_ST_RESET       5
`define RSHR_IRQ_RESTART    0
`define RSHR_IRQ_STOP       1
`define RSHR_IRQ_JOB_END    2
`define RSHR_IRQ_RESET      3
`define RSHR_CFG_RESET      8'h00
`endif

//--- hdl/rshr_pkg.sv
package rshr_pkg;
    typedef enum logic [2:0] {
        RSHR_REACT_STOP     = 3'h0,
        RSHR_REACT_CONTINUE = 3'h1,
        RSHR_REACT_FINISH   = 3'h2,
        RSHR_REACT_SUBST    = 3'h3,
        RSHR_REACT_KEEP     = 3'h4
    } rshr_react_t;

    typedef enum logic [1:0] {
        RSHR_RS_IDLE = 2'b00,
        RSHR_RS_FLAG = 2'b01,
        RSHR_RS_DONE = 2'b11
    } rshr_rs_state_t;
endpackage : rshr_pkg

//--- hdl/rshr_top.sv
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rshr_params.svh"
module rshr_top
    import rshr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        host_startup,
    input  wire logic        cpu_run,
    input  wire logic        count_active,
    input  wire logic        count_periodic,
    input  wire logic        meas_active,
    input  wire logic        count_limit_hit,
    input  wire logic        dout_use,
    input  wire logic [1:0]  dout_engine,
    output logic             count_abort,
    output logic             meas_abort,
    output logic             module_reset,
    output logic [1:0]       dout,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [7:0]     awaddr_q;
    logic           aw_have_q;
    logic [31:0]    wdata_q;
    logic [3:0]     wstrb_q;
    logic           w_have_q;
    logic           wr_fire;
    logic           ack_req_q;
    rshr_react_t    react_q;
    logic           run_always_q;
    rshr_react_t    react_new_q;
    logic           run_new_q;
    logic           params_pending_q;
    logic [1:0]     subst_q;
    rshr_rs_state_t rs_q;
    logic           cpu_run_q;
    logic           stopped_q;
    logic           finishing_q;
    logic           hold_q;
    logic [1:0]     hold_val_q;
    logic           off_q;
    logic [3:0]     irq_stat_q;
    logic [3:0]     irq_mask_q;
    logic [3:0]     irq_ev;
    logic           stop_edge;
    logic           run_edge;
    logic           params_diff;
    logic           load_cfg;
    logic [31:0]    rd_mux;
    rshr_react_t    react_wr;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
    assign s_axi_bresp   = (awaddr_q > `RSHR_ADDR_IRQ_MASK || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    assign stop_edge     = cpu_run_q && !cpu_run;
    assign run_edge      = !cpu_run_q && cpu_run;
    assign load_cfg      = wr_fire && awaddr_q == `RSHR_ADDR_CFG && wstrb_q[1] && wdata_q[`RSHR_CFG_LOAD_BIT];
    assign params_diff   = params_pending_q && (react_new_q != react_q || run_new_q != run_always_q);
    assign irq           = |(irq_stat_q & irq_mask_q);
    // Out-of-range codes fall back to the safe STOP reaction
    assign react_wr      = (wdata_q[2:0] > 3'h4) ? RSHR_REACT_STOP : rshr_react_t'(wdata_q[2:0]);

    // Write address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `RSHR_ADDR_CTRL:     rd_mux = {31'h0, ack_req_q};
            `RSHR_ADDR_CFG:      rd_mux = {27'h0, run_always_q, 1'b0, react_q};
            `RSHR_ADDR_SUBST:    rd_mux = {30'h0, subst_q};
            `RSHR_ADDR_STATUS:   rd_mux = {26'h0, module_reset, stopped_q, meas_active,
                                           count_active, rs_q == RSHR_RS_DONE, rs_q == RSHR_RS_FLAG};
            `RSHR_ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
            `RSHR_ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > `RSHR_ADDR_IRQ_MASK || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_req_q   <= 1'b0;
            subst_q     <= 2'h0;
            irq_mask_q  <= 4'h0;
            react_new_q <= RSHR_REACT_STOP;
            run_new_q   <= 1'b0;
        end else if (wr_fire && wstrb_q[0]) begin
            case (awaddr_q)
                `RSHR_ADDR_CTRL:     ack_req_q <= wdata_q[`RSHR_CTRL_ACK_REQ];
                `RSHR_ADDR_SUBST:    subst_q <= wdata_q[1:0];
                `RSHR_ADDR_IRQ_MASK: irq_mask_q <= wdata_q[3:0];
                `RSHR_ADDR_CFG: begin
                    react_new_q <= react_wr;
                    run_new_q   <= wdata_q[`RSHR_CFG_RUN_BIT];
                end
                default: ;
            endcase
        end
    end

    // parameters adopted by load or at stop-to-run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            react_q          <= RSHR_REACT_STOP;
            run_always_q     <= 1'b0;
            params_pending_q <= 1'b0;
        end else if (load_cfg && cpu_run) begin
            // The pending copy is written at this same edge, so take the word itself
            react_q          <= react_wr;
            run_always_q     <= wdata_q[`RSHR_CFG_RUN_BIT];
            params_pending_q <= 1'b0;
        end else if (load_cfg) begin
            params_pending_q <= 1'b1;
        end else if (run_edge && params_pending_q) begin
            react_q          <= react_new_q;
            run_always_q     <= run_new_q;
            params_pending_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rs_q <= RSHR_RS_FLAG;
        end else if (host_startup) begin
            rs_q <= RSHR_RS_FLAG;
        end else begin
            case (rs_q)
                RSHR_RS_FLAG: if (ack_req_q) rs_q <= RSHR_RS_DONE;
                RSHR_RS_DONE: if (!ack_req_q) rs_q <= RSHR_RS_IDLE;
                RSHR_RS_IDLE: ;
                default:      rs_q <= RSHR_RS_IDLE;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_run_q   <= 1'b1;
            stopped_q   <= 1'b0;
            finishing_q <= 1'b0;
        end else begin
            cpu_run_q <= cpu_run;
            if (stop_edge) begin
                stopped_q   <= 1'b1;
                finishing_q <= react_q == RSHR_REACT_FINISH && count_active;
            end else if (run_edge) begin
                stopped_q   <= 1'b0;
                finishing_q <= 1'b0;
            end else if (finishing_q && count_limit_hit) begin
                finishing_q <= 1'b0;
            end
        end
    end

    always_comb begin
        count_abort = 1'b0;
        meas_abort  = 1'b0;
        if (stop_edge) begin
            count_abort = react_q != RSHR_REACT_CONTINUE && react_q != RSHR_REACT_FINISH;
            meas_abort  = react_q != RSHR_REACT_CONTINUE;
        end else if (stopped_q && finishing_q && count_limit_hit) begin
            // Periodic mode would reload at the limit; stop it after this period
            count_abort = count_periodic;
        end
        if (module_reset) begin
            count_abort = 1'b1;
            meas_abort  = 1'b1;
        end
    end
    assign module_reset = run_edge && (run_always_q || params_diff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q     <= 1'b0;
            hold_val_q <= 2'h0;
            off_q      <= 1'b0;
        end else if (stop_edge) begin
            case (react_q)
                RSHR_REACT_STOP: off_q <= 1'b1;
                RSHR_REACT_SUBST: begin
                    hold_q     <= 1'b1;
                    hold_val_q <= meas_active ? 2'h0 : subst_q;
                end
                RSHR_REACT_KEEP: begin
                    hold_q     <= 1'b1;
                    hold_val_q <= dout;
                end
                RSHR_REACT_FINISH: off_q <= !count_active;
                default: ;
            endcase
        end else if (finishing_q && count_limit_hit) begin
            off_q <= 1'b1;
        end else if (load_cfg && react_wr != react_q) begin
            hold_q     <= 1'b0;
            hold_val_q <= 2'h0;
            off_q      <= 1'b0;
        end else if (cpu_run && !stop_edge) begin
            off_q <= 1'b0;
            if (dout_use) hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout <= 2'h0;
        end else if (hold_q) begin
            dout <= hold_val_q;
        end else if (off_q) begin
            dout <= 2'h0;
        end else begin
            dout <= dout_engine;
        end
    end

    // Set wins over write-one-to-clear
    assign irq_ev = {module_reset, finishing_q && count_limit_hit, stop_edge, host_startup};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 4'h0;
        end else if (wr_fire && awaddr_q == `RSHR_ADDR_IRQ_STAT && wstrb_q[0]) begin
            irq_stat_q <= (irq_stat_q & ~wdata_q[3:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    a_flag_to_done: assert property (@(posedge aclk) disable iff (!aresetn)
        rs_q == RSHR_RS_FLAG && ack_req_q && !host_startup |=> rs_q == RSHR_RS_DONE)
        else $error("Restart flag not cleared on ack request");
    a_done_held: assert property (@(posedge aclk) disable iff (!aresetn)
        rs_q == RSHR_RS_DONE && ack_req_q && !host_startup |=> rs_q == RSHR_RS_DONE)
        else $error("Ack done dropped while request high");
    a_startup_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        host_startup |=> rs_q == RSHR_RS_FLAG)
        else $error("Startup did not set restart flag");
    a_stop_abort: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_edge && react_q == RSHR_REACT_STOP |-> count_abort ##2 dout == 2'h0)
        else $error("Stop reaction failed");
    a_continue_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_edge && react_q == RSHR_REACT_CONTINUE && !module_reset |-> !count_abort && !meas_abort)
        else $error("Continue reaction aborted");
    a_finish_meas: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_edge && react_q == RSHR_REACT_FINISH |-> meas_abort && !count_abort)
        else $error("Finish reaction wrong abort");
    a_subst_out: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_edge && react_q == RSHR_REACT_SUBST && !meas_active && !module_reset |-> ##2 dout == $past(subst_q, 2))
        else $error("Substitute not driven");
    a_always_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        run_edge && run_always_q |-> module_reset && count_abort && meas_abort)
        else $error("Always reset not applied");
    c_restart_done: cover property (@(posedge aclk) disable iff (!aresetn) rs_q == RSHR_RS_DONE);
    c_finish_end: cover property (@(posedge aclk) disable iff (!aresetn) finishing_q && count_limit_hit);
    c_subst_stop: cover property (@(posedge aclk) disable iff (!aresetn) stop_edge && react_q == RSHR_REACT_SUBST);
endmodule : rshr_top

//--- sim/rshr_engine_model.sv
`timescale 1ns/1ps
module rshr_engine_model (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic cnt_go,
    input  wire logic per_go,
    input  wire logic meas_go,
    input  wire logic lim_go,
    input  wire logic count_abort,
    input  wire logic meas_abort,
    output logic      count_active,
    output logic      count_periodic,
    output logic      meas_active,
    output logic      count_limit_hit
);
    // Limit only counts while a job runs, so a stray strobe cannot end nothing
    assign count_limit_hit = lim_go && count_active;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_active   <= 1'b0;
            count_periodic <= 1'b0;
        end else if (cnt_go) begin
            count_active   <= 1'b1;
            count_periodic <= per_go;
        end else if (count_abort || (count_limit_hit && !count_periodic)) begin
            // Periodic jobs roll into a new period; only an abort ends them
            count_active <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meas_active <= 1'b0;
        end else if (meas_go) begin
            meas_active <= 1'b1;
        end else if (meas_abort) begin
            meas_active <= 1'b0;
        end
    end
endmodule : rshr_engine_model

//--- sim/test_restart_and_host_stop_reaction.sv
`timescale 1ns/1ps
`include "rshr_params.svh"
module test_restart_and_host_stop_reaction;
    import rshr_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, host_startup, cpu_run, count_active, count_periodic, meas_active;
    logic count_limit_hit, dout_use, count_abort, meas_abort, module_reset, irq;
    logic [1:0]  dout_engine, dout, s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic cnt_go, per_go, meas_go, lim_go;
    logic [1:0]  e, e2, s;
    int bad_count, n_checks;

    rshr_top dut_u (.aclk, .aresetn, .host_startup, .cpu_run, .count_active, .count_periodic,
        .meas_active, .count_limit_hit, .dout_use, .dout_engine, .count_abort, .meas_abort,
        .module_reset, .dout, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    rshr_engine_model eng_u (.aclk, .aresetn, .cnt_go, .per_go, .meas_go, .lim_go, .count_abort,
        .meas_abort, .count_active, .count_periodic, .meas_active, .count_limit_hit);

    always #4 aclk = ~aclk;

    task results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Each channel is released at the edge that took it; sampled at negedge to avoid races
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        int n;
        n = 0;
        b = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 200) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
            n++;
        end
        // Let an edge pass so the next call never re-raises bready in this time step
        tick(1);
        if (!b) begin
            chk("write timeout", 0, 1);
            results;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ar, r;
        int n;
        n = 0;
        r = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r && n < 200) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
            n++;
        end
        // Let an edge pass so the next call never re-raises rready in this time step
        tick(1);
        if (!r) begin
            chk("read timeout", 0, 1);
            results;
        end
    endtask : rd

    task tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : tick

    task start(input logic per, input logic meas);
        cnt_go <= 1'b1;
        per_go <= per;
        meas_go <= meas;
        tick(1);
        cnt_go <= 1'b0;
        meas_go <= 1'b0;
        tick(1);
    endtask : start

    function automatic logic [1:0] exp_dout(input int r);
        case (r)
            0: return 2'h0;
            3: return s;
            4: return e;
            default: return e2;
        endcase
    endfunction : exp_dout

    initial begin
        repeat (50000) @(posedge aclk);
        chk("global timeout", 0, 1);
        results;
    end

    initial begin
        {aresetn, host_startup, dout_use, cnt_go, per_go, meas_go, lim_go} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dout_engine} = '0;
        s_axi_wstrb = 4'hf;
        cpu_run = 1'b1;
        void'($urandom(75));
        tick(10);
        aresetn <= 1'b1;
        tick(1);
        rd(`RSHR_ADDR_STATUS);
        chk("restart flag", d & 32'h3, 32'h1);
        wr(`RSHR_ADDR_CTRL, 32'h1);
        rd(`RSHR_ADDR_STATUS);
        chk("ack done", d & 32'h3, 32'h2);
        // release only once flag is clear
        wr(`RSHR_ADDR_CTRL, 32'h0);
        rd(`RSHR_ADDR_STATUS);
        chk("ack cleared", d & 32'h3, 32'h0);
        host_startup <= 1'b1;
        tick(1);
        host_startup <= 1'b0;
        rd(`RSHR_ADDR_STATUS);
        chk("startup flag", d & 32'h3, 32'h1);
        rd(8'h40);
        chk("unmapped read", rs, 32'h2);
        wr(8'h44, 32'h0);
        chk("unmapped write", rs, 32'h2);
        for (int r = 0; r < 5; r++) begin
            e = 2'($urandom_range(1, 3));
            e2 = e ^ 2'h1;
            s = 2'($urandom);
            wr(`RSHR_ADDR_SUBST, {30'h0, s});
            wr(`RSHR_ADDR_CFG, 32'h100 | r);
            dout_engine <= e;
            start(1'b0, r == 2);
            cpu_run <= 1'b0;
            dout_engine <= e2;
            #1;
            chk("stop count abort", count_abort, r == 0 || r >= 3);
            if (r == 2) chk("finish meas abort", meas_abort, 1);
            tick(3);
            chk("stopped outputs", dout, exp_dout(r));
            if (r == 2) begin
                lim_go <= 1'b1;
                tick(1);
                lim_go <= 1'b0;
                tick(3);
                chk("finish outputs off", {count_active, dout}, 0);
            end
            cpu_run <= 1'b1;
            #1;
            chk("no abort unchanged", count_abort, 0);
            tick(3);
            if (r >= 3) chk("held after run", dout, exp_dout(r));
            dout_use <= 1'b1;
            tick(1);
            dout_use <= 1'b0;
            tick(3);
            chk("outputs reused", dout, e2);
        end
        wr(`RSHR_ADDR_CFG, 32'h102);
        start(1'b1, 1'b0);
        cpu_run <= 1'b0;
        #1;
        chk("periodic runs on", count_abort, 0);
        tick(2);
        lim_go <= 1'b1;
        #1;
        chk("periodic ends at limit", count_abort, 1);
        tick(1);
        lim_go <= 1'b0;
        cpu_run <= 1'b1;
        tick(3);
        wr(`RSHR_ADDR_CFG, 32'h111);
        start(1'b0, 1'b0);
        cpu_run <= 1'b0;
        tick(3);
        cpu_run <= 1'b1;
        #1;
        chk("always reset", {count_abort, module_reset}, 32'h3);
        tick(3);
        wr(`RSHR_ADDR_CFG, 32'h101);
        start(1'b0, 1'b0);
        cpu_run <= 1'b0;
        tick(2);
        wr(`RSHR_ADDR_CFG, 32'h111);
        cpu_run <= 1'b1;
        #1;
        chk("changed params abort", count_abort, 1);
        tick(3);
        rd(`RSHR_ADDR_CFG);
        chk("adopted config", d & 32'h17, 32'h11);
        wr(`RSHR_ADDR_IRQ_MASK, 32'h2);
        #1;
        chk("stop irq", irq, 1);
        wr(`RSHR_ADDR_IRQ_MASK, 32'h0);
        #1;
        chk("masked irq", irq, 0);
        wr(`RSHR_ADDR_IRQ_STAT, 32'hf);
        wr(`RSHR_ADDR_IRQ_MASK, 32'hf);
        #1;
        chk("cleared irq", irq, 0);
        results;
    end
endmodule : test_restart_and_host_stop_reaction
